// ---- core/mic_pkg.sv ----
// Purpose: shared types and constants for the memory integrity checker
// Assumes: one core clock, synchronous active-low reset
// Notes: protection modes are selected by input, not by register
package mic_pkg;
    localparam int WAYS = 4;
    localparam int WAY_W = 2;
    localparam int DATA_W = 32;
    localparam int CHK_W = 7;
    localparam int TAG_W = 20;
    localparam int TCHK_W = 6;
    localparam int ADDR_W = 32;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [7:0] INFO_RST = 8'h00;
    localparam int INFO_SRC_POS = 0;
    localparam int INFO_KIND_POS = 2;
    localparam int INFO_DEFER_POS = 4;

    typedef enum logic [1:0] {
        MIC_PROT_PARITY,
        MIC_PROT_SEC,
        MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT,
        MIC_PROT_NONE
    } mic_prot_t;

    // check result of one read, from the memory's own checker
    typedef struct packed {
        logic valid;
        logic deferred;
        logic single_err;
        logic dual_err;
        logic [ADDR_W-1:0] addr;
    } mic_chk_t;

    typedef struct packed {
        logic valid;
        logic forced_miss;
        logic [TAG_W-1:0] tag;
        logic [TCHK_W-1:0] exp_chk;
        logic [ADDR_W-1:0] addr;
    } mic_tag_req_t;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [TCHK_W-1:0] chk;
    } mic_tag_entry_t;

    typedef struct packed {
        logic tag_single;
        logic tag_dual;
        logic dirty_uncorr;
        logic done;
    } mic_fill_chk_t;

    typedef struct packed {
        logic valid;
        logic [7:0] info;
        logic [ADDR_W-1:0] addr;
    } mic_err_rec_t;
endpackage : mic_pkg

// ---- core/mic_checker.sv ----
// Purpose: integrity checking and error reporting for local memories
// Assumes: memory arrays and check-bit generators sit outside; inputs synchronous
// Notes: check bits are combined with data at write; decisions here drive core and cache
`timescale 1ns/1ps
// Summary of operation
// - icache parity error in read cycle drops hit and starts a line fill
// - after icache data error the erroring way becomes the fill victim
// - deferred icache parity error raises program trap on first issued instruction
// - icache writes carry precomputed check bits together with the data
// - cache data arrays need no reset; tag invalidation suffices
// - in-cycle icache correction gives a correction indication
// - deferred icache correction still gives a correction indication
// - icache dual error in cycle drops hit, fills, forces failing way
// - deferred dual icache error raises program trap on first issued instruction
// - any scratch error, or a tag fill error that traps or is corrected in a cycle without one, updates data trap info and address registers
// - data scratch parity error raises data integrity trap
// - data scratch writes store precomputed check bits; byte writes may use RMW
// - every data scratch correction is signalled to the core
// - data scratch dual error sends error with data, raising data trap
// - data tag way hits only if stored check and tag both match
// - all ways miss starts fill; tag and dirty data checked during fetch
// - parity tag or dirty error during fill traps, discards, cancels writeback
// - correctable tag error without a dirty data error writes corrected tag back, discards, indicates correction
// - uncorrectable dirty data error with correcting tags raises data trap
// - dual tag or dirty error traps and discards the fetched data
// - line invalidation is checked as a forced tag miss
// - any instruction-side error updates program trap info and address registers
module mic_checker (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire mic_pkg::mic_prot_t i_ic_prot,
    input wire mic_pkg::mic_prot_t i_ds_prot,
    input wire mic_pkg::mic_prot_t i_dt_prot,
    input wire mic_pkg::mic_chk_t i_ic_chk,
    input wire logic [mic_pkg::WAY_W-1:0] i_ic_way,
    input wire logic i_ic_raw_hit,
    input wire logic i_ic_fill_return,
    input wire logic i_issue_first,
    input wire logic i_ic_wr,
    input wire logic [mic_pkg::DATA_W-1:0] i_ic_wdata,
    input wire logic [mic_pkg::CHK_W-1:0] i_ic_wchk,
    input wire mic_pkg::mic_chk_t i_ds_chk,
    input wire logic i_ds_wr,
    input wire logic [mic_pkg::DATA_W-1:0] i_ds_wdata,
    input wire logic [mic_pkg::CHK_W-1:0] i_ds_wchk,
    input wire mic_pkg::mic_tag_req_t i_dt_req,
    input wire mic_pkg::mic_tag_entry_t [mic_pkg::WAYS-1:0] i_dt_entry,
    input wire mic_pkg::mic_fill_chk_t i_dt_fill,
    output logic o_ic_hit,
    output logic o_ic_fill_start,
    output logic o_ic_force_victim,
    output logic [mic_pkg::WAY_W-1:0] o_ic_victim_way,
    output logic o_ic_arr_wr,
    output logic [mic_pkg::DATA_W+mic_pkg::CHK_W-1:0] o_ic_arr_wword,
    output logic o_ds_arr_wr,
    output logic [mic_pkg::DATA_W+mic_pkg::CHK_W-1:0] o_ds_arr_wword,
    output logic [mic_pkg::WAYS-1:0] o_dt_way_hit,
    output logic o_dt_fill_start,
    output logic o_dt_fill_discard,
    output logic o_dt_wb_cancel,
    output logic o_dt_tag_writeback,
    output logic o_program_integrity_trap,
    output logic o_data_integrity_trap,
    output logic o_correction,
    output logic [mic_pkg::CNT_W-1:0] o_corr_count,
    output mic_pkg::mic_err_rec_t o_program_error_trap_info,
    output mic_pkg::mic_err_rec_t o_data_error_trap_info
);
    typedef enum {
        MIC_FILL_IDLE,
        MIC_FILL_FETCH
    } mic_fill_st_t;

    logic ic_now;
    logic ic_def;
    logic ic_hit_kill;
    logic ic_corr;
    logic ic_trap;
    logic ds_corr;
    logic ds_err;
    logic dt_corr;
    logic dt_err;
    logic dt_all_miss;
    logic dt_tag_fail;
    logic ic_pend_q;
    logic [mic_pkg::WAY_W-1:0] ic_way_q;
    logic ic_trap_pend_q;
    logic [mic_pkg::CNT_W-1:0] cnt_q;
    mic_fill_st_t fill_q;
    mic_pkg::mic_err_rec_t prog_q;
    mic_pkg::mic_err_rec_t data_q;

    assign ic_now = i_ic_chk.valid && !i_ic_chk.deferred;
    assign ic_def = i_ic_chk.valid && i_ic_chk.deferred;
    // parity any error, single_correct_double_detect dual error: drop hit in read cycle
    assign ic_hit_kill = ic_now && ((i_ic_prot == mic_pkg::MIC_PROT_PARITY
        && (i_ic_chk.single_err || i_ic_chk.dual_err))
        || (i_ic_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT && i_ic_chk.dual_err));
    assign o_ic_hit = i_ic_raw_hit && !ic_hit_kill;
    assign o_ic_fill_start = ic_hit_kill;
    assign ic_corr = i_ic_chk.valid && i_ic_chk.single_err && !i_ic_chk.dual_err
        && (i_ic_prot == mic_pkg::MIC_PROT_SEC || i_ic_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT);
    assign ic_trap = ic_def && ((i_ic_prot == mic_pkg::MIC_PROT_PARITY
        && (i_ic_chk.single_err || i_ic_chk.dual_err))
        || (i_ic_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT && i_ic_chk.dual_err));

    // remember failing way until the fill returns
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            ic_pend_q <= 1'b0;
            ic_way_q <= '0;
        end
        else if (ic_hit_kill)
        begin
            ic_pend_q <= 1'b1;
            ic_way_q <= i_ic_way;
        end
        else if (i_ic_fill_return)
        begin
            ic_pend_q <= 1'b0;
        end
    end
    assign o_ic_force_victim = ic_pend_q && i_ic_fill_return;
    assign o_ic_victim_way = ic_way_q;

    // trap held until first instruction of that fetch issues
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
            ic_trap_pend_q <= 1'b0;
        else if (ic_trap)
            ic_trap_pend_q <= 1'b1;
        else if (i_issue_first)
            ic_trap_pend_q <= 1'b0;
    end
    assign o_program_integrity_trap = ic_trap_pend_q && i_issue_first;

    // arrays are never cleared; data and check bits go in one word
    assign o_ic_arr_wr = i_ic_wr;
    assign o_ic_arr_wword = {i_ic_wchk, i_ic_wdata};
    assign o_ds_arr_wr = i_ds_wr;
    assign o_ds_arr_wword = {i_ds_wchk, i_ds_wdata};

    assign ds_corr = i_ds_chk.valid && i_ds_chk.single_err && !i_ds_chk.dual_err
        && (i_ds_prot == mic_pkg::MIC_PROT_SEC || i_ds_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT);
    assign ds_err = i_ds_chk.valid && ((i_ds_prot == mic_pkg::MIC_PROT_PARITY
        && (i_ds_chk.single_err || i_ds_chk.dual_err))
        || (i_ds_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT && i_ds_chk.dual_err));

    // data tag compare per way
    for (genvar w = 0; w < mic_pkg::WAYS; w++)
    begin : g_way
        assign o_dt_way_hit[w] = i_dt_req.valid && !i_dt_req.forced_miss
            && i_dt_entry[w].chk == i_dt_req.exp_chk
            && i_dt_entry[w].tag == i_dt_req.tag;
    end
    assign dt_all_miss = i_dt_req.valid && (o_dt_way_hit == '0);
    assign o_dt_fill_start = dt_all_miss && fill_q == MIC_FILL_IDLE;

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
            fill_q <= MIC_FILL_IDLE;
        else
        begin
            case (fill_q)
                MIC_FILL_IDLE:
                    if (o_dt_fill_start)
                        fill_q <= MIC_FILL_FETCH;
                MIC_FILL_FETCH:
                    if (i_dt_fill.done)
                        fill_q <= MIC_FILL_IDLE;
                default:
                    fill_q <= MIC_FILL_IDLE;
            endcase
        end
    end

    // checks performed during the fetch, judged at completion
    assign dt_tag_fail = (i_dt_prot == mic_pkg::MIC_PROT_PARITY
        && (i_dt_fill.tag_single || i_dt_fill.tag_dual))
        || (i_dt_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT && i_dt_fill.tag_dual);
    assign dt_err = fill_q == MIC_FILL_FETCH && i_dt_fill.done
        && (dt_tag_fail || i_dt_fill.dirty_uncorr);
    assign dt_corr = fill_q == MIC_FILL_FETCH && i_dt_fill.done && i_dt_fill.tag_single
        && !i_dt_fill.tag_dual
        && (i_dt_prot == mic_pkg::MIC_PROT_SEC || i_dt_prot == mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT);
    assign o_dt_tag_writeback = dt_corr && !dt_err;
    assign o_dt_fill_discard = dt_err || dt_corr;
    assign o_dt_wb_cancel = dt_err;
    assign o_data_integrity_trap = ds_err || dt_err;

    assign o_correction = ic_corr || ds_corr || o_dt_tag_writeback;

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
            cnt_q <= mic_pkg::CNT_RST;
        else if (o_correction && cnt_q != mic_pkg::CNT_MAX)
            cnt_q <= cnt_q + 1'b1;
    end
    assign o_corr_count = cnt_q;

    // program-side error record
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
            prog_q <= '{valid: 1'b0, info: mic_pkg::INFO_RST, addr: '0};
        else if (i_ic_chk.valid && (i_ic_chk.single_err || i_ic_chk.dual_err))
        begin
            prog_q.valid <= 1'b1;
            prog_q.info <= mic_pkg::INFO_RST | (8'(i_ic_prot) << mic_pkg::INFO_SRC_POS)
                | (8'({i_ic_chk.dual_err, i_ic_chk.single_err}) << mic_pkg::INFO_KIND_POS)
                | (8'(i_ic_chk.deferred) << mic_pkg::INFO_DEFER_POS);
            prog_q.addr <= i_ic_chk.addr;
        end
    end
    assign o_program_error_trap_info = prog_q;

    // data-side error record; scratch has priority over tag fill
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
            data_q <= '{valid: 1'b0, info: mic_pkg::INFO_RST, addr: '0};
        else if (i_ds_chk.valid && (i_ds_chk.single_err || i_ds_chk.dual_err))
        begin
            data_q.valid <= 1'b1;
            data_q.info <= (8'(i_ds_prot) << mic_pkg::INFO_SRC_POS)
                | (8'({i_ds_chk.dual_err, i_ds_chk.single_err}) << mic_pkg::INFO_KIND_POS)
                | (8'(i_ds_chk.deferred) << mic_pkg::INFO_DEFER_POS);
            data_q.addr <= i_ds_chk.addr;
        end
        else if (dt_err || dt_corr)
        begin
            data_q.valid <= 1'b1;
            data_q.info <= (8'(i_dt_prot) << mic_pkg::INFO_SRC_POS)
                | (8'({dt_err, dt_corr}) << mic_pkg::INFO_KIND_POS);
            data_q.addr <= i_dt_req.addr;
        end
    end
    assign o_data_error_trap_info = data_q;

    AST_IC_HIT_DROP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        ic_hit_kill |-> !o_ic_hit && o_ic_fill_start)
        else $error("hit not dropped on icache error");
    AST_IC_VICTIM: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        ic_hit_kill && !i_ic_fill_return ##1 (!ic_hit_kill && i_ic_fill_return)
        |-> o_ic_force_victim && o_ic_victim_way == $past(i_ic_way))
        else $error("wrong victim way");
    AST_IC_TRAP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        ic_trap ##1 i_issue_first |-> o_program_integrity_trap)
        else $error("program trap missing");
    AST_DS_TRAP: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_ds_chk.valid && i_ds_chk.single_err && i_ds_prot == mic_pkg::MIC_PROT_PARITY
        |-> o_data_integrity_trap)
        else $error("data trap missing");
    AST_TAG_HIT: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_dt_way_hit[0] |-> i_dt_entry[0].tag == i_dt_req.tag && !i_dt_req.forced_miss)
        else $error("tag hit without match");
    AST_DISCARD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        dt_err |-> o_dt_fill_discard && o_dt_wb_cancel && o_data_integrity_trap)
        else $error("fill not discarded");
    AST_CNT_INC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_correction && cnt_q != mic_pkg::CNT_MAX |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("counter did not step");
    AST_CNT_HOLD: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        !o_correction |=> $stable(cnt_q))
        else $error("counter moved without correction");
    AST_DREC: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_ds_chk.valid && i_ds_chk.dual_err |=> data_q.valid
        && data_q.addr == $past(i_ds_chk.addr))
        else $error("data error record not updated");
    COV_IC_FILL: cover property (@(posedge i_mclk) ic_hit_kill ##[1:20] o_ic_force_victim);
    COV_DT_CORR: cover property (@(posedge i_mclk) o_dt_tag_writeback);
    COV_PTRAP: cover property (@(posedge i_mclk) o_program_integrity_trap);
endmodule : mic_checker

// ---- verif/mic_fill_model.sv ----
// Purpose: far-side model of the cache fill fetch
// Assumes: fill start pulses are sampled at the rising edge
// Notes: latency and fill result flags are set by the bench
`timescale 1ns/1ps
module mic_fill_model (
    input wire logic i_mclk,
    input wire logic i_ic_start,
    input wire logic i_dt_start,
    input wire logic [3:0] i_lat,
    input wire logic [2:0] i_flags,
    output logic o_ic_return,
    output mic_pkg::mic_fill_chk_t o_dt_fill
);
    int ic_n = 0;
    int dt_n = 0;
    logic ic_s;
    logic dt_s;
    initial o_ic_return = 1'b0;
    initial o_dt_fill = '0;
    always @(posedge i_mclk)
    begin
        ic_s = i_ic_start;
        dt_s = i_dt_start;
        #1;
        ic_n = ic_s ? int'(i_lat) : ((ic_n > 0) ? ic_n - 1 : 0);
        dt_n = dt_s ? int'(i_lat) : ((dt_n > 0) ? dt_n - 1 : 0);
        o_ic_return = (ic_n == 1);
        // flags mean nothing outside done, so scramble them
        o_dt_fill = (dt_n == 1) ? {i_flags, 1'b1} : {~o_dt_fill[3:1], 1'b0};
    end
endmodule : mic_fill_model

// ---- verif/memory_integrity_checker_test.sv ----
// Purpose: self-checking bench for the memory integrity checker
// Assumes: fill fetch side modelled by mic_fill_model
// Notes: driver queues expected outputs, monitor compares at the falling edge
`timescale 1ns/1ps
module memory_integrity_checker_test;
    typedef struct packed {
        logic [2:0] ic;
        logic [1:0] vway;
        logic [2:0] tc;
        logic [3:0] wh;
        logic [3:0] df;
    } mic_obs_t;
    logic i_mclk, i_resetn, i_ic_raw_hit, i_ic_fill_return, i_issue_first, i_ic_wr, i_ds_wr;
    mic_pkg::mic_prot_t i_ic_prot, i_ds_prot, i_dt_prot;
    mic_pkg::mic_chk_t i_ic_chk, i_ds_chk;
    logic [1:0] i_ic_way, o_ic_victim_way;
    logic [mic_pkg::DATA_W-1:0] i_ic_wdata, i_ds_wdata, a, t;
    logic [mic_pkg::CHK_W-1:0] i_ic_wchk, i_ds_wchk;
    mic_pkg::mic_tag_req_t i_dt_req;
    mic_pkg::mic_tag_entry_t [3:0] i_dt_entry;
    mic_pkg::mic_fill_chk_t i_dt_fill;
    logic o_ic_hit, o_ic_fill_start, o_ic_force_victim, o_ic_arr_wr, o_ds_arr_wr;
    logic o_dt_fill_start, o_dt_fill_discard, o_dt_wb_cancel, o_dt_tag_writeback;
    logic o_program_integrity_trap, o_data_integrity_trap, o_correction, obs_en;
    logic [38:0] o_ic_arr_wword, o_ds_arr_wword;
    logic [3:0] o_dt_way_hit, lat;
    logic [15:0] o_corr_count, exp_cnt;
    mic_pkg::mic_err_rec_t o_program_error_trap_info, o_data_error_trap_info;
    logic [2:0] flags;
    mic_obs_t got, ev, em, g;
    mic_obs_t exp_q [$];
    int bad_count, checked, cyc;
    logic [2:0] fl [7] = '{3'h0, 3'h4, 3'h1, 3'h4, 3'h1, 3'h2, 3'h4};
    logic [4:0] ex [7] = '{5'h00, 5'h1C, 5'h1C, 5'h0B, 5'h1C, 5'h1C, 5'h0B};
    logic [4:0] dsc [5] = '{5'h01, 5'h05, 5'h09, 5'h12, 5'h15};
    assign got = {o_ic_hit, o_ic_fill_start, o_ic_force_victim, o_ic_victim_way,
        o_program_integrity_trap, o_data_integrity_trap, o_correction, o_dt_way_hit,
        o_dt_fill_start, o_dt_fill_discard, o_dt_wb_cancel, o_dt_tag_writeback};
    mic_checker dut_u (
        .i_mclk, .i_resetn, .i_ic_prot, .i_ds_prot, .i_dt_prot, .i_ic_chk, .i_ic_way,
        .i_ic_raw_hit, .i_ic_fill_return, .i_issue_first, .i_ic_wr, .i_ic_wdata, .i_ic_wchk,
        .i_ds_chk, .i_ds_wr, .i_ds_wdata, .i_ds_wchk, .i_dt_req, .i_dt_entry, .i_dt_fill,
        .o_ic_hit, .o_ic_fill_start, .o_ic_force_victim, .o_ic_victim_way, .o_ic_arr_wr,
        .o_ic_arr_wword, .o_ds_arr_wr, .o_ds_arr_wword, .o_dt_way_hit, .o_dt_fill_start,
        .o_dt_fill_discard, .o_dt_wb_cancel, .o_dt_tag_writeback, .o_program_integrity_trap,
        .o_data_integrity_trap, .o_correction, .o_corr_count, .o_program_error_trap_info,
        .o_data_error_trap_info
    );
    mic_fill_model fill_u (
        .i_mclk, .i_ic_start(o_ic_fill_start), .i_dt_start(o_dt_fill_start), .i_lat(lat),
        .i_flags(flags), .o_ic_return(i_ic_fill_return), .o_dt_fill(i_dt_fill)
    );
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checked++;
        if (seen !== want)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask : check
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    function automatic mic_obs_t mk(input logic [2:0] ic, input logic [2:0] tc,
        input logic [3:0] wh, input logic [3:0] df);
        return '{ic, 2'h0, tc, wh, df};
    endfunction : mk
    task automatic step(input logic ob, input mic_obs_t x);
        if (ob)
            exp_q.push_back(x);
        obs_en = ob;
        @(posedge i_mclk);
        #1;
    endtask : step
    // drops every request, then lets n edges pass
    task automatic idle(input int n);
        i_ic_chk.valid = 1'b0;
        i_ds_chk.valid = 1'b0;
        i_dt_req.valid = 1'b0;
        i_issue_first = 1'b0;
        i_ic_raw_hit = 1'b0;
        i_ic_wr = 1'b0;
        i_ds_wr = 1'b0;
        repeat (n) step(1'b0, '0);
    endtask : idle
    task automatic park();
        for (int w = 0; w < 4; w++)
            i_dt_entry[w] = '{20'($urandom), 6'h3F};
    endtask : park
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    always @(negedge i_mclk)
    begin
        if (obs_en)
        begin
            em = exp_q.pop_front();
            g = got;
            if (!em.ic[0])
                g.vway = em.vway;
            check(g, em);
            check(o_corr_count, exp_cnt);
            if (em.tc[0])
                exp_cnt = exp_cnt + 16'h0001;
        end
    end
    initial
    begin
        {i_resetn, obs_en, i_ic_raw_hit, i_issue_first, i_ic_wr, i_ds_wr, i_ic_way} = '0;
        {i_ic_chk, i_ds_chk, i_dt_req, i_ic_wdata, i_ds_wdata, i_ic_wchk, i_ds_wchk} = '0;
        {bad_count, checked, cyc, exp_cnt, lat, flags, a} = '0;
        i_ic_prot = mic_pkg::MIC_PROT_PARITY;
        i_ds_prot = mic_pkg::MIC_PROT_PARITY;
        i_dt_prot = mic_pkg::MIC_PROT_PARITY;
        void'($urandom(48));
        park();
        repeat (6) @(posedge i_mclk);
        #1 i_resetn = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            lat = (k == 1) ? 4'h1 : 4'h3;
            a = $urandom;
            i_ic_way = 2'($urandom);
            i_ic_prot = (k == 1) ? mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT : mic_pkg::MIC_PROT_PARITY;
            i_ic_chk = '{1'b1, 1'b0, k == 0, k == 1, a};
            i_ic_raw_hit = 1'b1;
            step(1'b1, mk(3'h2, 3'h0, 4'h0, 4'h0));
            idle(int'(lat) - 1);
            ev = mk(3'h1, 3'h0, 4'h0, 4'h0);
            ev.vway = i_ic_way;
            step(1'b1, ev);
            check(o_program_error_trap_info, {1'b1, (k == 1) ? 8'h0A : 8'h04, a});
        end
        for (int k = 0; k < 3; k++)
        begin
            i_ic_prot = (k == 2) ? mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT : mic_pkg::MIC_PROT_SEC;
            i_ic_chk = '{1'b1, k == 1, 1'b1, 1'b0, a};
            i_ic_raw_hit = (k != 1);
            step(1'b1, mk((k != 1) ? 3'h4 : 3'h0, 3'h1, 4'h0, 4'h0));
        end
        for (int k = 0; k < 2; k++)
        begin
            i_ic_prot = (k == 1) ? mic_pkg::MIC_PROT_SINGLE_CORRECT_DOUBLE_DETECT : mic_pkg::MIC_PROT_PARITY;
            i_ic_chk = '{1'b1, 1'b1, k == 0, k == 1, a};
            i_ic_raw_hit = 1'b0;
            step(1'b1, mk(3'h0, 3'h0, 4'h0, 4'h0));
            if (k == 0)
                idle(1);
            else
                i_ic_chk.valid = 1'b0;
            i_issue_first = 1'b1;
            step(1'b1, mk(3'h0, 3'h4, 4'h0, 4'h0));
            i_issue_first = 1'b1;
            step(1'b1, mk(3'h0, 3'h0, 4'h0, 4'h0));
        end
        foreach (dsc[j])
        begin
            a = $urandom;
            i_ds_prot = mic_pkg::mic_prot_t'(dsc[j][4:3]);
            i_ds_chk = '{1'b1, dsc[j][2], dsc[j][0], dsc[j][1], a};
            ev = mk(3'h0, (dsc[j][1] || dsc[j][4:3] == 2'h0) ? 3'h2 : 3'h1, 4'h0, 4'h0);
            step(1'b1, ev);
            check(o_data_error_trap_info, {1'b1, 3'h0, dsc[j][2:0], dsc[j][4:3], a});
        end
        idle(1);
        repeat (4)
        begin
            i_ic_wdata = $urandom;
            i_ic_wchk = 7'($urandom);
            i_ds_wdata = $urandom;
            i_ds_wchk = 7'($urandom);
            i_ic_wr = 1'b1;
            i_ds_wr = 1'b1;
            @(negedge i_mclk);
            check({o_ic_arr_wr, o_ic_arr_wword}, {1'b1, i_ic_wchk, i_ic_wdata});
            check({o_ds_arr_wr, o_ds_arr_wword}, {1'b1, i_ds_wchk, i_ds_wdata});
            step(1'b0, '0);
        end
        for (int m = 0; m < 4; m++)
        begin
            t = $urandom;
            i_dt_req = '{1'b1, 1'b0, t[19:0], t[25:20], a};
            i_dt_entry[m] = '{t[19:0], t[25:20]};
            i_dt_entry[(m + 1) % 4] = '{t[19:0], ~t[25:20]};
            i_dt_entry[(m + 2) % 4] = '{~t[19:0], t[25:20]};
            i_dt_entry[(m + 3) % 4] = '{~t[19:0], ~t[25:20]};
            step(1'b1, mk(3'h0, 3'h0, 4'h1 << m, 4'h0));
        end
        park();
        for (int k = 0; k < 7; k++)
        begin
            lat = 4'h2 + 4'(k % 2);
            flags = fl[k];
            i_dt_prot = mic_pkg::mic_prot_t'((k < 3) ? 0 : ((k < 5) ? 1 : 2));
            i_dt_req = '{1'b1, k == 6, 20'h00000, 6'h00, a};
            if (k == 6)
                i_dt_entry[0] = '{20'h00000, 6'h00};
            step(1'b1, mk(3'h0, 3'h0, 4'h0, 4'h8));
            park();
            step(1'b1, mk(3'h0, 3'h0, 4'h0, 4'h0));
            idle(int'(lat) - 2);
            ev = mk(3'h0, {1'b0, ex[k][4], ex[k][0]}, 4'h0, {1'b0, ex[k][3:1]});
            step(1'b1, ev);
            idle(1);
        end
        idle(2);
        report_and_stop();
    end
endmodule : memory_integrity_checker_test
